// file: common/lcd_pkg.sv
// Purpose: Shared register map, field layout and timing constants.
// Assumes: 8-bit register port with 7-bit word addresses.
// Notes:   Pixel row for common c and segment group g sits at 8c+g.
`default_nettype none
package lcd_pkg;

    localparam int          ADDR_W          = 7;
    localparam logic [6:0]  CONTROL_OFFSET  = 7'h00;
    localparam logic [6:0]  PHASE_OFFSET    = 7'h01;
    localparam logic [6:0]  STATUS_OFFSET   = 7'h02;
    localparam logic [6:0]  SEG_ENABLE_BASE = 7'h08;
    localparam logic [6:0]  PIXEL_BASE      = 7'h40;

    localparam int          EN_BIT          = 7;
    localparam int          SLEEP_BIT       = 6;
    localparam int          CS_LSB          = 3;
    localparam int          MUX_LSB         = 0;
    localparam int          WAVE_BIT        = 7;
    localparam int          PRESC_LSB       = 0;
    localparam int          STAT_RUN_BIT    = 7;
    localparam int          STAT_PHASE_BIT  = 3;

    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [7:0]  PHASE_RESET     = 8'h00;
    localparam logic [7:0]  SEG_RESET       = 8'h00;
    localparam logic [7:0]  PIXEL_RESET     = 8'h00;

    localparam logic [1:0]  CS_NONE         = 2'h3;
    localparam int          CLOCK_HZ        = 20_000_000;
    localparam int          FIXED_DIV_DFLT  = 8192;

    // Pre-divider ahead of the common ring: 4 static, 2 at 1/2, else 1.
    function automatic logic [2:0] mux_prediv(input logic [2:0] code);
        if (code == 3'h0)
            return 3'h4;
        else if (code == 3'h1)
            return 3'h2;
        else
            return 3'h1;
    endfunction : mux_prediv

endpackage : lcd_pkg
`default_nettype wire

// file: design/lcd_sync.sv
// Purpose: Three-stage synchroniser with agreement filter per bit.
// Assumes: Inputs are asynchronous to clock.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module lcd_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // One process owns every bit, so no bit of level_out has two writers.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            level_out <= '0;
        else
            level_out <= (stage2_reg & stage3_reg)
                       | (level_out & (stage2_reg ^ stage3_reg));
    end
endmodule : lcd_sync
`default_nettype wire

// file: design/lcd_timing.sv
// Purpose: Fixed divider, prescaler and common/phase slice sequencer.
// Assumes: src_edge is a one-cycle pulse per selected source edge.
// Notes:   Half-ticks run at twice the base rate so Type-A slices fit.
`timescale 1ns/1ps
`default_nettype none
module lcd_timing #(
    parameter int FIXED_DIV = lcd_pkg::FIXED_DIV_DFLT
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       src_edge,
    input  wire logic [2:0] mux_code,
    input  wire logic       wave_b,
    input  wire logic [3:0] presc,
    output logic      [2:0] com_idx,
    output logic            phase,
    output logic            slice_end
);
    localparam int HALF = FIXED_DIV / 2;
    localparam int HW   = (HALF > 1) ? $clog2(HALF) : 1;

    logic [HW-1:0] half_cnt_reg;
    logic [7:0]    slice_cnt_reg;
    logic [3:0]    slice_idx_reg;
    logic          frame_phase_reg;
    logic          half_tick;
    logic [7:0]    base_len;
    logic [7:0]    slice_len;
    logic [3:0]    last_idx;

    assign half_tick = run && src_edge && (half_cnt_reg == HW'(HALF - 1));
    assign base_len  = 8'(lcd_pkg::mux_prediv(mux_code))
                     * ({4'h0, presc} + 8'h01);
    assign slice_len = wave_b ? {base_len[6:0], 1'b0} : base_len;
    assign last_idx  = wave_b ? {1'b0, mux_code}
                              : {mux_code, 1'b1};
    assign slice_end = half_tick && (slice_cnt_reg >= slice_len - 8'h01);

    always_ff @(posedge clock)
    begin
        if (!rst_n || !run)
            half_cnt_reg <= '0;
        else if (src_edge)
            half_cnt_reg <= half_tick ? '0 : half_cnt_reg + HW'(1);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || !run)
            slice_cnt_reg <= 8'h00;
        else if (slice_end)
            slice_cnt_reg <= 8'h00;
        else if (half_tick)
            slice_cnt_reg <= slice_cnt_reg + 8'h01;
    end

    // Commons above the selected count are never visited.
    always_ff @(posedge clock)
    begin
        if (!rst_n || !run)
            slice_idx_reg <= 4'h0;
        else if (slice_end)
            slice_idx_reg <= (slice_idx_reg >= last_idx) ? 4'h0
                           : slice_idx_reg + 4'h1;
    end

    // Type-B turns polarity only at the frame boundary.
    always_ff @(posedge clock)
    begin
        if (!rst_n || !run)
            frame_phase_reg <= 1'b0;
        else if (slice_end && slice_idx_reg >= last_idx)
            frame_phase_reg <= !frame_phase_reg;
    end

    assign com_idx = wave_b ? slice_idx_reg[2:0] : slice_idx_reg[3:1];
    assign phase   = wave_b ? frame_phase_reg : slice_idx_reg[0];
endmodule : lcd_timing
`default_nettype wire

// file: design/segment_lcd_driver.sv
// Purpose: Register-controlled static or multiplexed segment LCD driver.
// Assumes: Clock sources arrive on pins; drive levels are digital.
// Notes:   Bias and contrast are outside this block.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_driver #(
    parameter int COMMONS   = 8,
    parameter int FIXED_DIV = lcd_pkg::FIXED_DIV_DFLT
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [6:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic [2:0]  clk_src,
    input  wire logic        cpu_sleep,
    input  wire logic [63:0] gpio_out,
    input  wire logic [63:0] gpio_oe,
    output logic      [7:0]  com_select,
    output logic             com_phase,
    output logic      [63:0] seg_pin_o,
    output logic      [63:0] seg_pin_oe,
    output logic             lcd_running
);
    generate
        if (COMMONS != 4 && COMMONS != 8)
            $error("COMMONS must be 4 or 8");
        if (FIXED_DIV < 2 || (FIXED_DIV % 2) != 0)
            $error("FIXED_DIV must be even and at least 2");
    endgenerate

    localparam logic [2:0] MUX_MASK = (COMMONS == 8) ? 3'h7 : 3'h3;

    logic [7:0]  control_reg;
    logic [7:0]  phase_reg;
    logic [7:0]  seg_enable_regs [8];
    logic [7:0]  pixel_data_regs [64];
    logic [2:0]  src_level;
    logic        src_prev_reg;
    logic        src_sel;
    logic        src_edge;
    logic        run;
    logic [2:0]  com_idx;
    logic        phase;
    logic        slice_end;
    logic [63:0] seg_dark;
    logic [63:0] seg_enable_bits;
    logic [1:0]  cs_field;
    logic [2:0]  common_count_field;

    assign cs_field = control_reg[lcd_pkg::CS_LSB +: 2];
    assign common_count_field = control_reg[2:0] & MUX_MASK;

    // sleep stops refresh only when allowed
    assign run = control_reg[lcd_pkg::EN_BIT]
              && !(cpu_sleep && control_reg[lcd_pkg::SLEEP_BIT]);

    lcd_sync #(
        .WIDTH (3)
    ) u_sync (
        .clock     (clock),
        .rst_n     (rst_n),
        .async_in  (clk_src),
        .level_out (src_level)
    );

    always_comb
    begin
        if (cs_field == lcd_pkg::CS_NONE)
            src_sel = 1'b0;
        else
            src_sel = src_level[cs_field];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            src_prev_reg <= 1'b0;
        else
            src_prev_reg <= src_sel;
    end

    assign src_edge = src_sel && !src_prev_reg;

    // prescaler and fixed divider live here
    // mux code sets pre-divide and ring length
    // slices per frame follow waveform type
    lcd_timing #(
        .FIXED_DIV (FIXED_DIV)
    ) u_timing (
        .clock     (clock),
        .rst_n     (rst_n),
        .run       (run),
        .src_edge  (src_edge),
        .mux_code  (common_count_field),
        .wave_b    (phase_reg[lcd_pkg::WAVE_BIT]),
        .presc     (phase_reg[lcd_pkg::PRESC_LSB +: 4]),
        .com_idx   (com_idx),
        .phase     (phase),
        .slice_end (slice_end)
    );

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            control_reg <= lcd_pkg::CONTROL_RESET;
        else if (wr && addr == lcd_pkg::CONTROL_OFFSET)
            control_reg <= wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            phase_reg <= lcd_pkg::PHASE_RESET;
        else if (wr && addr == lcd_pkg::PHASE_OFFSET)
            phase_reg <= wdata;
    end

    genvar k;
    generate
        for (k = 0; k < 8; k++)
        begin : g_seg
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    seg_enable_regs[k] <= lcd_pkg::SEG_RESET;
                else if (wr && addr == lcd_pkg::SEG_ENABLE_BASE + 7'(k))
                    seg_enable_regs[k] <= wdata;
            end
            assign seg_enable_bits[8*k +: 8] = seg_enable_regs[k];
            // row 8c+g feeds group g for common c
            assign seg_dark[8*k +: 8] = pixel_data_regs[{com_idx, 3'(k)}];
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 64; i++)
                pixel_data_regs[i] <= lcd_pkg::PIXEL_RESET;
        end
        else if (wr && addr >= lcd_pkg::PIXEL_BASE)
            pixel_data_regs[addr[5:0]] <= wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (!rd)
            rdata <= 8'h00;
        else if (addr == lcd_pkg::CONTROL_OFFSET)
            rdata <= control_reg;
        else if (addr == lcd_pkg::PHASE_OFFSET)
            rdata <= phase_reg;
        else if (addr == lcd_pkg::STATUS_OFFSET)
            rdata <= {run, 3'h0, phase, com_idx};
        else if (addr >= lcd_pkg::SEG_ENABLE_BASE
                 && addr < lcd_pkg::SEG_ENABLE_BASE + 7'h08)
            rdata <= seg_enable_regs[addr[2:0]];
        else if (addr >= lcd_pkg::PIXEL_BASE)
            rdata <= pixel_data_regs[addr[5:0]];
        else
            rdata <= 8'h00;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n || !run)
        begin
            com_select <= 8'h00;
            com_phase  <= 1'b0;
        end
        else
        begin
            com_select <= 8'h01 << com_idx;
            com_phase  <= phase;
        end
    end

    // enabled pins go to the LCD, others to GPIO
    // a dark pixel drives opposite to the common
    // only visited commons ever select pixel rows
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            seg_pin_o  <= 64'h0;
            seg_pin_oe <= 64'h0;
        end
        else
        begin
            for (int s = 0; s < 64; s++)
            begin
                if (seg_enable_bits[s])
                begin
                    seg_pin_oe[s] <= 1'b1;
                    seg_pin_o[s]  <= run && (seg_dark[s] ^ phase);
                end
                else
                begin
                    seg_pin_oe[s] <= gpio_oe[s];
                    seg_pin_o[s]  <= gpio_out[s];
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            lcd_running <= 1'b0;
        else
            lcd_running <= run;
    end

    // Checks below watch only what this block drives.
    logic [2:0] last_com_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            last_com_reg <= 3'h0;
        else if (run)
            last_com_reg <= com_idx;
    end

    chk_enable_off_idle: assert property (
        @(posedge clock) disable iff (!rst_n)
        !control_reg[lcd_pkg::EN_BIT] |=> com_select == 8'h00)
        else $error("commons driven while disabled");

    chk_sleep_keeps_run: assert property (
        @(posedge clock) disable iff (!rst_n)
        control_reg[lcd_pkg::EN_BIT] && !control_reg[lcd_pkg::SLEEP_BIT]
        |=> lcd_running)
        else $error("refresh stopped with sleep bit clear");

    chk_sleep_stops_run: assert property (
        @(posedge clock) disable iff (!rst_n)
        cpu_sleep && control_reg[lcd_pkg::SLEEP_BIT] |=> !lcd_running)
        else $error("refresh kept during allowed sleep");

    chk_no_source_still: assert property (
        @(posedge clock) disable iff (!rst_n)
        cs_field == lcd_pkg::CS_NONE |-> !src_edge)
        else $error("edge seen with no source selected");

    chk_common_in_range: assert property (
        @(posedge clock) disable iff (!rst_n)
        run |-> com_idx <= common_count_field)
        else $error("common beyond selected count");

    chk_common_onehot: assert property (
        @(posedge clock) disable iff (!rst_n)
        run ##1 run |-> $onehot(com_select)
                       && com_select == (8'h01 << $past(com_idx)))
        else $error("common select not one-hot");

    chk_gpio_passes: assert property (
        @(posedge clock) disable iff (!rst_n)
        rst_n && seg_enable_bits[0] == 1'b0 ##1 seg_enable_bits[0] == 1'b0
        |-> seg_pin_oe[0] == $past(gpio_oe[0])
            && seg_pin_o[0] == $past(gpio_out[0]))
        else $error("GPIO not passed on unowned pin");

    chk_lcd_owns_pin: assert property (
        @(posedge clock) disable iff (!rst_n)
        seg_enable_bits[63] |=> seg_pin_oe[63])
        else $error("owned segment pin not driven");

    chk_pixel_drive: assert property (
        @(posedge clock) disable iff (!rst_n)
        run && seg_enable_bits[8]
        |=> seg_pin_o[8] == ($past(pixel_data_regs[{com_idx, 3'h1}][0])
                             ^ $past(phase)))
        else $error("segment level does not follow pixel bit");

    chk_pixel_write: assert property (
        @(posedge clock) disable iff (!rst_n)
        wr && addr == 7'h7F |=> pixel_data_regs[63] == $past(wdata))
        else $error("pixel register write lost");

    chk_ring_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        run && slice_end && phase_reg[lcd_pkg::WAVE_BIT]
        && com_idx < common_count_field
        |=> !run || com_idx == last_com_reg + 3'h1)
        else $error("Type-B ring skipped a common");

    chk_read_return: assert property (
        @(posedge clock) disable iff (!rst_n)
        rd && addr == lcd_pkg::CONTROL_OFFSET |=> rdata == $past(control_reg))
        else $error("control readback wrong");

    cov_typea_run: cover property (
        @(posedge clock) disable iff (!rst_n)
        run && !phase_reg[lcd_pkg::WAVE_BIT] && slice_end);

    cov_typeb_run: cover property (
        @(posedge clock) disable iff (!rst_n)
        run && phase_reg[lcd_pkg::WAVE_BIT] && slice_end && com_idx == 3'h7);

    cov_sleep_stop: cover property (
        @(posedge clock) disable iff (!rst_n)
        lcd_running ##1 !lcd_running && cpu_sleep);

endmodule : segment_lcd_driver
`default_nettype wire

// file: testbench/lcd_glass_model.sv
// Purpose: Passive glass model that latches what each pixel last saw.
// Assumes: Digital drive: a pixel is dark when its segment level differs
//          from the common phase during that common's slice.
// Notes:   Bit c*64+s of seen holds segment s on common c.
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_model (
    input  wire logic         clock,
    input  wire logic [7:0]   com_select,
    input  wire logic         com_phase,
    input  wire logic [63:0]  seg_pin_o,
    output logic      [511:0] seen
);
    initial seen = '0;
    always @(posedge clock)
    begin
        for (int c = 0; c < 8; c++)
        begin
            if (com_select[c])
                seen[c*64 +: 64] <= seg_pin_o ^ {64{com_phase}};
        end
    end
endmodule : lcd_glass_model
`default_nettype wire

// file: testbench/segment_lcd_driver_bench.sv
// Purpose: Self-checking bench for the segment LCD driver.
// Assumes: Fixed divider shortened to 4 source edges.
// Notes:   Frames are timed in source edges; sync jitter allows +-2.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp); \
        end \
    end
module segment_lcd_driver_bench;
    localparam int FDIV = 4;
    logic         clock     = 1'b0;
    logic         rst_n     = 1'b0;
    logic         osc       = 1'b0;
    logic [6:0]   addr      = '0;
    logic [7:0]   wdata     = '0;
    logic         wr        = 1'b0;
    logic         rd        = 1'b0;
    logic [2:0]   src_mask  = '0;
    logic         cpu_sleep = 1'b0;
    logic [63:0]  gpio_out  = 64'h0123_4567_89AB_CDEF;
    logic [63:0]  gpio_oe   = 64'hFF00_F0F0_0F0F_00FF;
    logic [2:0]   clk_src;
    logic [7:0]   rdata;
    logic [7:0]   com_select;
    logic [7:0]   com_mask;
    logic         com_phase;
    logic         lcd_running;
    logic [63:0]  seg_pin_o;
    logic [63:0]  seg_pin_oe;
    logic [511:0] seen;
    int           n_mismatch  = 0;
    int           comparisons = 0;
    int           src_cnt     = 0;

    // The source oscillator is unrelated in phase to the system clock.
    assign clk_src = {3{osc}} & src_mask;
    always #25 clock = ~clock;
    always #170 osc = ~osc;
    always @(posedge osc) src_cnt++;

    segment_lcd_driver #(.COMMONS(8), .FIXED_DIV(FDIV)) u_dut (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .clk_src(clk_src),
        .cpu_sleep(cpu_sleep), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .com_select(com_select), .com_phase(com_phase),
        .seg_pin_o(seg_pin_o), .seg_pin_oe(seg_pin_oe),
        .lcd_running(lcd_running)
    );

    lcd_glass_model u_glass (
        .clock(clock), .com_select(com_select), .com_phase(com_phase),
        .seg_pin_o(seg_pin_o), .seen(seen)
    );

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_read

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle

    function automatic logic [7:0] ctl(bit en, bit slp, int src, int mux);
        return (8'(en) << lcd_pkg::EN_BIT) | (8'(slp) << lcd_pkg::SLEEP_BIT)
            | (8'(src) << lcd_pkg::CS_LSB) | (8'(mux) << lcd_pkg::MUX_LSB);
    endfunction : ctl

    function automatic logic [7:0] ph(bit wave, int presc);
        return (8'(wave) << lcd_pkg::WAVE_BIT) | 8'(presc);
    endfunction : ph

    function automatic logic [7:0] pix(int c, int g);
        return 8'(c * 37 + g * 11 + 5);
    endfunction : pix

    function automatic logic [8:0] state(bit phase_only);
        return phase_only ? {8'h00, com_phase} : {com_select, com_phase};
    endfunction : state

    task automatic wait_for(input bit po, input int bound, output bit ok);
        logic [8:0] last;
        last = state(po);
        ok = 1'b0;
        repeat (bound)
        begin
            @(posedge clock);
            #1;
            com_mask = com_mask | com_select;
            if (state(po) !== last)
            begin
                ok = 1'b1;
                break;
            end
        end
    endtask : wait_for

    task automatic must(input bit phase_only);
        bit ok;
        wait_for(phase_only, 3000, ok);
        if (!ok)
        begin
            n_mismatch++;
            $display("mismatch at %0t: wait timed out", $time);
            print_verdict();
        end
    endtask : must

    // Configuration is complete before the enable bit is set.
    task automatic restart(input int mux, input int src, input logic [7:0] p);
        reg_write(lcd_pkg::CONTROL_OFFSET, ctl(0, 0, src, mux));
        reg_write(lcd_pkg::PHASE_OFFSET, p);
        reg_write(lcd_pkg::CONTROL_OFFSET, ctl(1, 0, src, mux));
    endtask : restart

    task automatic t_reset_values();
        logic [7:0] d;
        reg_read(lcd_pkg::CONTROL_OFFSET, d);
        `CHECK(d, lcd_pkg::CONTROL_RESET)
        reg_read(lcd_pkg::PHASE_OFFSET, d);
        `CHECK(d, lcd_pkg::PHASE_RESET)
        reg_read(lcd_pkg::SEG_ENABLE_BASE + 7'h07, d);
        `CHECK(d, lcd_pkg::SEG_RESET)
        reg_read(lcd_pkg::PIXEL_BASE + 7'h3F, d);
        `CHECK(d, lcd_pkg::PIXEL_RESET)
        reg_read(7'h05, d);
        `CHECK(d, 8'h00)
        `CHECK({lcd_running, com_select}, 9'h000)
        `CHECK(seg_pin_oe, gpio_oe)
    endtask : t_reset_values

    task automatic t_regs();
        logic [7:0] d;
        reg_write(lcd_pkg::CONTROL_OFFSET, ctl(0, 1, 2, 5));
        reg_write(lcd_pkg::PHASE_OFFSET, ph(1, 10));
        reg_read(lcd_pkg::CONTROL_OFFSET, d);
        `CHECK(d, 8'h55)
        reg_read(lcd_pkg::PHASE_OFFSET, d);
        `CHECK(d, 8'h8A)
        reg_write(lcd_pkg::CONTROL_OFFSET, 8'h00);
    endtask : t_regs

    task automatic t_seg_enable();
        logic [63:0] m;
        logic [7:0]  v;
        for (int k = 0; k < 8; k++)
        begin
            v = 8'hA5 ^ 8'(k * 17);
            m[8*k +: 8] = v;
            reg_write(lcd_pkg::SEG_ENABLE_BASE + 7'(k), v);
        end
        idle(3);
        `CHECK(seg_pin_oe, m | (gpio_oe & ~m))
        `CHECK(seg_pin_o, gpio_out & ~m)
        reg_read(lcd_pkg::SEG_ENABLE_BASE + 7'h03, v);
        `CHECK(v, m[31:24])
    endtask : t_seg_enable

    task automatic t_type_b_codes();
        int code_tab [9] = '{0, 1, 2, 3, 4, 5, 6, 3, 7};
        int lp_tab [9]   = '{0, 0, 0, 0, 0, 0, 0, 3, 0};
        int k;
        int t0;
        int exp;
        for (int i = 0; i < 8; i++)
        begin
            reg_write(lcd_pkg::SEG_ENABLE_BASE + 7'(i), 8'hFF);
            for (int g = 0; g < 8; g++)
                reg_write(lcd_pkg::PIXEL_BASE + 7'(8 * i + g), pix(i, g));
        end
        src_mask <= 3'b001;
        for (int i = 0; i < 9; i++)
        begin
            k = (code_tab[i] == 0) ? 4 : (code_tab[i] == 1) ? 2 : 1;
            restart(code_tab[i], 0, ph(1, lp_tab[i]));
            must(1);
            com_mask = 8'h00;
            t0 = src_cnt;
            must(1);
            exp = FDIV * k * (code_tab[i] + 1) * (lp_tab[i] + 1);
            `CHECK(src_cnt - t0 inside {[exp-2:exp+2]}, 1'b1)
            `CHECK(com_mask, 8'((9'h001 << (code_tab[i] + 1)) - 1))
        end
        must(1);
        must(1);
        for (int c = 0; c < 8; c++)
            for (int g = 0; g < 8; g++)
                `CHECK(seen[c*64 + 8*g +: 8], pix(c, g))
    endtask : t_type_b_codes

    task automatic t_type_a();
        restart(2, 0, ph(0, 0));
        repeat (20)
        begin
            if (com_select === 8'h01 && com_phase === 1'b0)
                break;
            must(0);
        end
        com_mask = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            `CHECK({com_select, com_phase}, {8'h01 << (i / 2), 1'(i)})
            must(0);
        end
        `CHECK(com_mask[7:3], 5'h00)
    endtask : t_type_a

    task automatic t_source_select();
        bit ok;
        src_mask <= 3'b010;
        for (int s = 0; s < 4; s++)
        begin
            restart(7, s, ph(1, 0));
            wait_for(1, 600, ok);
            `CHECK(ok, 1'(s == 1))
        end
        src_mask <= 3'b001;
    endtask : t_source_select

    task automatic t_sleep();
        reg_write(lcd_pkg::CONTROL_OFFSET, ctl(1, 1, 0, 7));
        @(posedge clock) cpu_sleep <= 1'b1;
        idle(4);
        `CHECK({lcd_running, com_select}, 9'h000)
        @(posedge clock) cpu_sleep <= 1'b0;
        idle(4);
        `CHECK(lcd_running, 1'b1)
        reg_write(lcd_pkg::CONTROL_OFFSET, ctl(1, 0, 0, 7));
        @(posedge clock) cpu_sleep <= 1'b1;
        idle(4);
        `CHECK(lcd_running, 1'b1)
        must(1);
        reg_write(lcd_pkg::CONTROL_OFFSET, ctl(0, 0, 0, 7));
        idle(4);
        `CHECK({lcd_running, com_select, com_phase}, 10'h000)
        `CHECK(seg_pin_o, 64'h0)
        @(posedge clock) cpu_sleep <= 1'b0;
    endtask : t_sleep

    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        idle(2);
        t_reset_values();
        t_regs();
        t_seg_enable();
        t_type_b_codes();
        t_type_a();
        t_source_select();
        t_sleep();
        print_verdict();
    end
endmodule : segment_lcd_driver_bench
`default_nettype wire
